// File: src/tmr8_wave.sv
module tmr8_wave
    import tmr8_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire tmr8_apb_req_t i_apb,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    input wire logic i_ext_count_pin,
    output logic o_wave_out_a,
    output logic o_wave_out_b,
    output logic [1:0] o_pin_override,
    output logic [1:0] o_pin_oe,
    output logic [2:0] o_flags
);

    // ******************************
    // decode helpers
    // ******************************
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m[0] == 1'b1);
    endfunction

    function automatic logic is_pc(input logic [2:0] m);
        is_pc = (m[1:0] == 2'h1);
    endfunction

    // next output level for one channel on a match or at TOP
    function automatic logic act_out(input logic [2:0] m,
                                     input logic [1:0] act,
                                     input logic cur,
                                     input logic down,
                                     input logic hit,
                                     input logic at_top,
                                     input logic ign,
                                     input logic tgl_ok);
        logic v;
        v = cur;
        if (!is_pwm(m)) begin
            if (hit) begin
                case (act)
                    TMR8_ACT_TGL: v = ~cur;
                    TMR8_ACT_CLR: v = 1'b0;
                    TMR8_ACT_SET: v = 1'b1;
                    default: v = cur;
                endcase
            end
        end else if (act[1]) begin
            if (is_pc(m)) begin
                if (hit && !ign) begin
                    v = act[0] ^ down;
                end
                if (at_top && ign) begin
                    v = act[0] ^ 1'b1;
                end
            end else begin
                if (at_top) begin
                    v = ~act[0];
                end
                if (hit && !ign) begin
                    v = act[0];
                end
                if (at_top && ign) begin
                    v = act[0];
                end
            end
        end else if (act == TMR8_ACT_TGL && tgl_ok && hit) begin
            v = ~cur; // channel A toggle with top from compare A
        end
        act_out = v;
    endfunction

    tmr8_state_t s_q;
    tmr8_state_t s_d;

    logic wr;
    logic rd;
    logic tick;
    logic [7:0] top;
    logic at_top;
    logic hit_a;
    logic hit_b;
    logic ign_a;
    logic ign_b;
    logic ext_rise;
    logic ext_fall;
    logic [7:0] wreg;
    logic [TMR8_PRE_W-1:0] pre_mask;

    // ******************************
    // combinational next state
    // ******************************
    always_comb begin
        s_d = s_q;
        wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
        // read captured in the setup cycle so data stands in the access
        rd = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
        wreg = i_apb.pwdata[7:0];

        // ext pin sampled always, even as output; sync then edge
        s_d.ext_sync = {s_q.ext_sync[0], i_ext_count_pin};
        s_d.ext_prev = s_q.ext_sync[1];
        ext_rise = s_q.ext_sync[1] && !s_q.ext_prev;
        ext_fall = !s_q.ext_sync[1] && s_q.ext_prev;

        // free-running prescaler shared by every divided source
        s_d.pre = s_q.pre + 1'b1;
        case (s_q.cs)
            TMR8_CS_DIV8: pre_mask = 10'h007;
            TMR8_CS_DIV64: pre_mask = 10'h03F;
            TMR8_CS_DIV256: pre_mask = 10'h0FF;
            TMR8_CS_DIV1024: pre_mask = 10'h3FF;
            default: pre_mask = 10'h000;
        endcase
        case (s_q.cs)
            TMR8_CS_STOP: tick = 1'b0;
            TMR8_CS_DIV1: tick = 1'b1;
            TMR8_CS_EXT_FALL: tick = ext_fall;
            TMR8_CS_EXT_RISE: tick = ext_rise;
            default: tick = ((s_q.pre & pre_mask) == pre_mask);
        endcase

        top = s_q.wgm[2] ? s_q.ocra : TMR8_MAX;
        at_top = (s_q.cnt == top);
        // compare runs always, blocked after a counter write
        hit_a = (s_q.cnt == s_q.ocra) && !s_q.block;
        hit_b = (s_q.cnt == s_q.ocrb) && !s_q.block;
        ign_a = is_pwm(s_q.wgm) && s_q.act_a[1] && (s_q.ocra == top);
        ign_b = is_pwm(s_q.wgm) && s_q.act_b[1] && (s_q.ocrb == top);

        if (tick) begin
            s_d.block = 1'b0;
            s_d.wave[0] = act_out(s_q.wgm, s_q.act_a, s_q.wave[0],
                                  s_q.down, hit_a, at_top, ign_a,
                                  s_q.wgm[2]);
            s_d.wave[1] = act_out(s_q.wgm, s_q.act_b, s_q.wave[1],
                                  s_q.down, hit_b, at_top, ign_b,
                                  1'b0);
            // match flags set on a real match only
            if (hit_a) s_d.flags[TMR8_F_MATCH_A] = 1'b1;
            if (hit_b) s_d.flags[TMR8_F_MATCH_B] = 1'b1;
            if (is_pc(s_q.wgm)) begin
                // top held one tick, then count down
                if (!s_q.down) begin
                    if (at_top) s_d.down = 1'b1;
                    else s_d.cnt = s_q.cnt + 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                    if (s_q.cnt == 8'h01) s_d.down = 1'b0;
                    if (s_q.cnt == 8'h01) s_d.flags[TMR8_F_OVF] = 1'b1;
                end
                if (at_top) begin
                    s_d.ocra = s_q.ocra_buf;
                    s_d.ocrb = s_q.ocrb_buf;
                end
            end else begin
                s_d.down = 1'b0;
                // wrap at top, or clear on compare A in TMR8_M_CTC
                if ((s_q.wgm == TMR8_M_CTC && hit_a) ||
                    (s_q.wgm != TMR8_M_NORMAL && at_top)) begin
                    s_d.cnt = TMR8_BOTTOM;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
                if (is_pwm(s_q.wgm) && at_top) begin
                    s_d.ocra = s_q.ocra_buf;
                    s_d.ocrb = s_q.ocrb_buf;
                end
                if ((s_q.wgm == TMR8_M_FAST_OCA) ? at_top
                        : (s_q.cnt == TMR8_MAX)) begin
                    s_d.flags[TMR8_F_OVF] = 1'b1;
                end
            end
        end

        // non-PWM compare values follow their buffers on the clock after a write, not at TOP
        if (!is_pwm(s_q.wgm)) begin
            s_d.ocra = s_d.ocra_buf;
            s_d.ocrb = s_d.ocrb_buf;
        end

        // register writes, one per access cycle
        if (wr) begin
            case (i_apb.paddr)
                TMR8_ADDR_CTRL_A: begin
                    s_d.act_a = wreg[TMR8_A_ACT_A_LSB +: 2];
                    s_d.act_b = wreg[TMR8_A_ACT_B_LSB +: 2];
                    s_d.wgm[1:0] = wreg[TMR8_A_WGM_LSB +: 2];
                end
                TMR8_ADDR_CTRL_B: begin
                    s_d.wgm[2] = wreg[TMR8_B_WGM2];
                    s_d.cs = wreg[TMR8_B_CS_LSB +: 3];
                    if (!is_pwm(s_q.wgm)) begin
                        if (wreg[TMR8_B_FORCE_A])
                            s_d.wave[0] = act_out(s_q.wgm, s_q.act_a,
                                s_d.wave[0], 1'b0, 1'b1, 1'b0, 1'b0,
                                1'b0);
                        if (wreg[TMR8_B_FORCE_B])
                            s_d.wave[1] = act_out(s_q.wgm, s_q.act_b,
                                s_d.wave[1], 1'b0, 1'b1, 1'b0, 1'b0,
                                1'b0);
                    end
                end
                TMR8_ADDR_COUNT: begin
                    s_d.cnt = wreg;
                    s_d.block = 1'b1;
                end
                TMR8_ADDR_CMP_A: s_d.ocra_buf = wreg;
                TMR8_ADDR_CMP_B: s_d.ocrb_buf = wreg;
                TMR8_ADDR_DIR: s_d.ddr = wreg[1:0];
                default: ;
            endcase
            // write one clears, but a same-cycle set wins
            if (i_apb.paddr == TMR8_ADDR_FLAGS) begin
                s_d.flags = s_q.flags & ~wreg[2:0];
                if (tick && hit_a) s_d.flags[TMR8_F_MATCH_A] = 1'b1;
                if (tick && hit_b) s_d.flags[TMR8_F_MATCH_B] = 1'b1;
                s_d.flags[TMR8_F_OVF] = s_d.flags[TMR8_F_OVF] |
                    (s_q.flags[TMR8_F_OVF] & ~wreg[TMR8_F_OVF]) |
                    (tick && (is_pc(s_q.wgm) ? (s_q.down &&
                    s_q.cnt == 8'h01) : ((s_q.wgm == TMR8_M_FAST_OCA)
                    ? at_top : (s_q.cnt == TMR8_MAX))));
            end
        end

        // read data, registered; reserved bits zero
        s_d.prdata = 32'h0000_0000;
        if (rd) begin
            case (i_apb.paddr)
                TMR8_ADDR_CTRL_A: s_d.prdata[7:0] = {s_q.act_a, s_q.act_b,
                    2'h0, s_q.wgm[1:0]};
                TMR8_ADDR_CTRL_B: s_d.prdata[7:0] = {4'h0, s_q.wgm[2],
                    s_q.cs};
                TMR8_ADDR_COUNT: s_d.prdata[7:0] = s_q.cnt;
                TMR8_ADDR_CMP_A: s_d.prdata[7:0] = s_q.ocra_buf;
                TMR8_ADDR_CMP_B: s_d.prdata[7:0] = s_q.ocrb_buf;
                TMR8_ADDR_FLAGS: s_d.prdata[2:0] = s_q.flags;
                TMR8_ADDR_DIR: s_d.prdata[1:0] = s_q.ddr;
                default: ;
            endcase
        end
    end

    // ******************************
    // state register
    // ******************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ******************************
    // outputs
    // ******************************
    // zero wait: read data is ready from the setup-cycle capture
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_prdata = s_q.prdata;
    assign o_wave_out_a = s_q.wave[0];
    assign o_wave_out_b = s_q.wave[1];
    assign o_flags = s_q.flags;
    assign o_pin_override = {s_q.act_b != TMR8_ACT_OFF,
                             s_q.act_a != TMR8_ACT_OFF};
    // override alone does not enable the driver
    assign o_pin_oe = o_pin_override & s_q.ddr;

endmodule

// File: src/tmr8_pkg.sv
package tmr8_pkg;

    // ******************************
    // register map (byte addresses)
    // ******************************
    localparam logic [7:0] TMR8_ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] TMR8_ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] TMR8_ADDR_COUNT = 8'h08;
    localparam logic [7:0] TMR8_ADDR_CMP_A = 8'h0C;
    localparam logic [7:0] TMR8_ADDR_CMP_B = 8'h10;
    localparam logic [7:0] TMR8_ADDR_FLAGS = 8'h14;
    localparam logic [7:0] TMR8_ADDR_DIR = 8'h18;

    // ******************************
    // field positions
    // ******************************
    localparam int TMR8_A_ACT_A_LSB = 6;
    localparam int TMR8_A_ACT_B_LSB = 4;
    localparam int TMR8_A_WGM_LSB = 0;
    localparam int TMR8_B_FORCE_A = 7;
    localparam int TMR8_B_FORCE_B = 6;
    localparam int TMR8_B_WGM2 = 3;
    localparam int TMR8_B_CS_LSB = 0;
    localparam int TMR8_F_OVF = 0;
    localparam int TMR8_F_MATCH_A = 1;
    localparam int TMR8_F_MATCH_B = 2;

    // ******************************
    // values and encodings
    // ******************************
    localparam logic [7:0] TMR8_MAX = 8'hFF;
    localparam logic [7:0] TMR8_BOTTOM = 8'h00;
    localparam logic [7:0] TMR8_RST8 = 8'h00;
    localparam logic [1:0] TMR8_ACT_OFF = 2'h0;
    localparam logic [1:0] TMR8_ACT_TGL = 2'h1;
    localparam logic [1:0] TMR8_ACT_CLR = 2'h2;
    localparam logic [1:0] TMR8_ACT_SET = 2'h3;
    localparam logic [2:0] TMR8_CS_STOP = 3'h0;
    localparam logic [2:0] TMR8_CS_DIV1 = 3'h1;
    localparam logic [2:0] TMR8_CS_DIV8 = 3'h2;
    localparam logic [2:0] TMR8_CS_DIV64 = 3'h3;
    localparam logic [2:0] TMR8_CS_DIV256 = 3'h4;
    localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7;
    localparam int TMR8_PRE_W = 10;

    typedef enum logic [2:0] {
        TMR8_M_NORMAL = 3'h0,
        TMR8_M_PC_FF = 3'h1,
        TMR8_M_CTC = 3'h2,
        TMR8_M_FAST_FF = 3'h3,
        TMR8_M_RSV4 = 3'h4,
        TMR8_M_PC_OCA = 3'h5,
        TMR8_M_RSV6 = 3'h6,
        TMR8_M_FAST_OCA = 3'h7
    } tmr8_mode_t;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tmr8_apb_req_t;

    // all state of the block
    typedef struct packed {
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [2:0] wgm;
        logic [2:0] cs;
        logic [7:0] cnt;
        logic [7:0] ocra_buf;
        logic [7:0] ocrb_buf;
        logic [7:0] ocra;
        logic [7:0] ocrb;
        logic [2:0] flags;
        logic [1:0] ddr;
        logic [1:0] wave;
        logic down;
        logic block;
        logic [TMR8_PRE_W-1:0] pre;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [31:0] prdata;
    } tmr8_state_t;

endpackage

// File: testbench/tmr8_wave_monitor.sv
// ****************************************
// port checker for the waveform timer
// ****************************************
module tmr8_wave_monitor
    import tmr8_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire tmr8_apb_req_t i_apb,
    input wire logic [31:0] o_prdata,
    input wire logic [1:0] o_pin_override,
    input wire logic [1:0] o_pin_oe,
    input wire logic [2:0] o_flags
);
    logic wr;
    logic rd;
    // completed accesses; pready is tied high so access == done
    assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
    // read data is captured at the setup edge and stands one cycle
    assign rd = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_oe_needs_ovr: assert property (
        (o_pin_oe & ~o_pin_override) == 2'h0)
        else $error("pin driver on without override");
    chk_ovr_follows_b: assert property (
        wr && i_apb.paddr == TMR8_ADDR_CTRL_A
        |=> o_pin_override[1] == |$past(i_apb.pwdata[5:4]))
        else $error("channel b override wrong");
    chk_oe_follows_dir: assert property (
        wr && i_apb.paddr == TMR8_ADDR_DIR
        |=> o_pin_oe == (o_pin_override & $past(i_apb.pwdata[1:0])))
        else $error("pin enable not override and direction");
    chk_ctrl_a_rsv: assert property (
        rd && i_apb.paddr == TMR8_ADDR_CTRL_A |=> o_prdata[3:2] == 2'h0)
        else $error("control a reserved bits nonzero");
    chk_ctrl_b_rsv: assert property (
        rd && i_apb.paddr == TMR8_ADDR_CTRL_B |=> o_prdata[7:4] == 4'h0)
        else $error("control b force or reserved bits nonzero");
    chk_flags_sticky: assert property (
        !(wr && i_apb.paddr == TMR8_ADDR_FLAGS)
        |=> (o_flags & $past(o_flags)) == $past(o_flags))
        else $error("flag dropped without write");
    chk_count_width: assert property (
        rd && i_apb.paddr == TMR8_ADDR_COUNT |=> o_prdata[31:8] == 24'h0)
        else $error("counter read wider than 8 bits");
    chk_cmp_width: assert property (
        rd && i_apb.paddr == TMR8_ADDR_CMP_B |=> o_prdata[31:8] == 24'h0)
        else $error("compare read wider than 8 bits");
endmodule

bind tmr8_wave tmr8_wave_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_apb(i_apb), .o_prdata(o_prdata), .o_pin_override(o_pin_override),
    .o_pin_oe(o_pin_oe), .o_flags(o_flags));

// File: testbench/tmr8_ext_src.sv
// ****************************************
// far side: pulses on the external count pin
// ****************************************
module tmr8_ext_src (
    input wire logic i_clk,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_pin = 1'b0;
    // slow pulses so the two-flop synchroniser never drops an edge
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_pin <= 1'b0;
        end
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// File: testbench/test_timer8_waveform_control.sv
// ****************************************
// self-checking bench for the waveform timer
// ****************************************
module test_timer8_waveform_control;
    import tmr8_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_n, pready, ext, wb;
    logic [31:0] prdata, d;
    logic [1:0] ovr, oe;
    logic [2:0] flags;
    tmr8_apb_req_t apb;
    int failures = 0, check_count = 0, cycles = 0, hi;
    tmr8_wave dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(apb),
        .o_pready(pready), .o_pslverr(), .o_prdata(prdata),
        .i_ext_count_pin(ext), .o_wave_out_a(), .o_wave_out_b(wb),
        .o_pin_override(ovr), .o_pin_oe(oe), .o_flags(flags));
    tmr8_ext_src u_src (.i_clk(i_clk), .o_pin(ext));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // hang guard: whole run is about 1300 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rng(input logic [31:0] got, input int lo, input int hi_);
        chk(got >= lo && got <= hi_, 32'h1);
    endtask
    // one apb transfer; read data is taken at the access edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd);
        apb.psel <= 1'b1;
        apb.pwrite <= w;
        apb.paddr <= a;
        apb.pwdata <= wd;
        @(posedge i_clk);
        apb.penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) @(posedge i_clk);
        d = prdata;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(d, exp);
    endtask
    task automatic t_regs();
        rd(TMR8_ADDR_CTRL_B, 32'h0);
        xfer(1'b1, TMR8_ADDR_CTRL_A, 32'hFC);
        rd(TMR8_ADDR_CTRL_A, 32'hF0);
        xfer(1'b1, TMR8_ADDR_CTRL_B, 32'hF8);
        rd(TMR8_ADDR_CTRL_B, 32'h08);
        xfer(1'b1, TMR8_ADDR_CTRL_B, 32'h0);
        xfer(1'b1, TMR8_ADDR_COUNT, 32'h5A);
        rd(TMR8_ADDR_COUNT, 32'h5A);
        xfer(1'b1, TMR8_ADDR_CMP_B, 32'h77);
        rd(TMR8_ADDR_CMP_B, 32'h77);
    endtask
    // channel b set, clear and toggle forces, then the direction gate
    task automatic t_force();
        logic [1:0] act[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
        xfer(1'b1, TMR8_ADDR_DIR, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, TMR8_ADDR_CTRL_A, {26'h0, act[i], 4'h0});
            chk(oe[1], 1'b0);
            chk(ovr[1], 1'b1);
            xfer(1'b1, TMR8_ADDR_CTRL_B, 32'h40);
            chk(wb, {31'h0, ~i[0]});
        end
        rd(TMR8_ADDR_FLAGS, 32'h0);
        xfer(1'b1, TMR8_ADDR_DIR, 32'h2);
        chk(oe[1], 1'b1);
        xfer(1'b1, TMR8_ADDR_CTRL_A, 32'h0);
        chk(ovr[1], 1'b0);
    endtask
    task automatic t_run(input logic [7:0] cs, input logic [7:0] start,
                         input int n);
        xfer(1'b1, TMR8_ADDR_COUNT, {24'h0, start});
        xfer(1'b1, TMR8_ADDR_CTRL_B, {24'h0, cs});
        repeat (n) @(posedge i_clk);
        xfer(1'b1, TMR8_ADDR_CTRL_B, 32'h0);
        xfer(1'b0, TMR8_ADDR_COUNT, 32'h0);
    endtask
    task automatic t_count();
        t_run(8'h02, 8'h00, 80);
        rng(d, 10, 12);
        t_run(8'h00, 8'h33, 40);
        chk(d, 32'h33);
        xfer(1'b1, TMR8_ADDR_FLAGS, 32'h7);
        t_run(8'h01, 8'hFE, 6);
        rng(d, 2, 8);
        xfer(1'b0, TMR8_ADDR_FLAGS, 32'h0);
        chk(d[0], 1'b1);
        xfer(1'b1, TMR8_ADDR_FLAGS, 32'h7);
        rd(TMR8_ADDR_FLAGS, 32'h0);
        xfer(1'b1, TMR8_ADDR_COUNT, 32'h0);
        xfer(1'b1, TMR8_ADDR_CTRL_B, 32'h07);
        u_src.pulses(5);
        xfer(1'b1, TMR8_ADDR_CTRL_B, 32'h06);
        u_src.pulses(3);
        xfer(1'b1, TMR8_ADDR_CTRL_B, 32'h0);
        rd(TMR8_ADDR_COUNT, 32'h8);
        xfer(1'b1, TMR8_ADDR_CTRL_A, 32'h02);
        xfer(1'b1, TMR8_ADDR_CMP_A, 32'h9);
        t_run(8'h01, 8'h00, 60);
        rng(d, 0, 9);
    endtask
    // fast pwm, clear on match, set at top: duty about half
    task automatic t_pwm();
        xfer(1'b1, TMR8_ADDR_CMP_B, 32'h80);
        xfer(1'b1, TMR8_ADDR_CTRL_A, 32'h23);
        t_run(8'h01, 8'h00, 300);
        xfer(1'b1, TMR8_ADDR_CTRL_B, 32'h01);
        hi = 0;
        repeat (512) begin
            @(posedge i_clk);
            if (wb === 1'b1) hi++;
        end
        rng(hi, 250, 266);
    endtask
    initial begin
        i_rst_n = 1'b0;
        apb = '0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_regs();
        t_force();
        t_count();
        t_pwm();
        final_report();
    end
endmodule
